// *** logic/tws_pkg.sv ***
// constants and state types for the two-wire register slave
// assumes one core clock domain and one link sampling clock domain
package tws_pkg;

  // write forms of the two selectable slave address bytes
  localparam logic [7:0] ADDR_BYTE_DEF = 8'h90; // address select pin low
  localparam logic [7:0] ADDR_BYTE_ALT = 8'hba; // address select pin high
  localparam int DIR_BIT = 0; // direction bit in the address byte
  localparam logic DIR_READ = 1'b1; // direction value for a read

  // serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // bits in each byte

  // internal register file
  localparam int REG_COUNT = 16; // implemented byte registers
  localparam int REG_IDX_W = 4; // index bits of the register file
  localparam logic [15:0] REG_LIMIT = 16'h0010; // first unmapped address
  localparam logic [15:0] REG_OVERRIDE = 16'h0000; // slave address override
  localparam logic [15:0] REG_STATUS = 16'h0001; // read-only write counter
  localparam logic [15:0] REG_CTRL = 16'h0002; // control byte shown on a port
  localparam int OVR_EN_BIT = 0; // override enable inside REG_OVERRIDE
  localparam logic [7:0] REG_RESET = 8'h00; // reset value of every register

  // link protocol states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RAH, ST_HACK, ST_RAL, ST_LACK,
    ST_WDAT, ST_DACK, ST_RDAT, ST_RMACK, ST_IGNORE
  } tws_state_e;

  // all state of the link domain
  typedef struct packed {
    logic [1:0] rst_sync; // reset synchroniser, bit 0 first
    logic [2:0] scl_s; // serial clock pin sampler, bit 0 first
    logic [2:0] sda_s; // serial data pin sampler, bit 0 first
    logic scl_q; // filtered serial clock
    logic sda_q; // filtered serial data
    logic [2:0] atg_s; // address toggle sampler
    logic [6:0] my_addr; // slave address in use
    logic [2:0] akt_s; // read answer toggle sampler
    logic [7:0] rd_buf; // last read answer
    tws_state_e st; // protocol state
    logic [3:0] cnt; // bit counter within a byte
    logic [7:0] shift; // shift register
    logic rd_mode; // current transfer is a read
    logic [15:0] reg_addr; // register address pointer
    logic req_tgl; // request toggle toward the core
    logic req_wr; // request is a write
    logic [15:0] req_addr; // request register address
    logic [7:0] req_data; // request write data
    logic sda_out; // level put on the data line
    logic sda_oe_n; // low while pulling the data line
  } tws_link_s;

  // all state of the core domain
  typedef struct packed {
    logic [2:0] sel_s; // address select pin sampler
    logic sel_q; // filtered address select level
    logic [2:0] rqt_s; // request toggle sampler
    logic [REG_COUNT-1:0][7:0] regs; // register file
    logic [7:0] wr_count; // writes taken
    logic [6:0] sent_addr; // slave address offered to the link
    logic addr_tgl; // toggles when sent_addr changes
    logic [7:0] rdata; // read answer
    logic ack_tgl; // toggles when rdata is valid
  } tws_core_s;

endpackage

// *** logic/tws_register_slave.sv ***
// two-wire serial slave giving a bus master access to internal registers
// assumes scl and sda arrive as open-drain pins from an external master,
// sampled by link_clk; the register file runs on clk
//
// Contract
// - master reads and writes internal registers
// - both lines high means link idle
// - sda falling while scl high is start
// - repeated start begins a fresh transfer
// - frame: start, address, register address, data, stop
// - pin low answers 0x90, high 0xba
// - register value overrides pin address
// - bytes are eight bits, msb first
// - every byte followed by acknowledge bit
// - one data bit per clock period
// - data changes only while clock low
// - pin selects between two slave addresses
// - bits seven to one address, bit zero direction
// - receiver pulls data low to acknowledge
`timescale 1ns/100ps
module tws_register_slave (
  input wire logic clk, // core clock, 50 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic link_clk, // link sampling clock
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data output level
  output logic sda_oe_n, // low while pulling the data line
  input wire logic address_select_pin, // picks the alternate address
  output logic [7:0] ctrl_o // control register contents
);

  tws_pkg::tws_link_s l_r; // link state
  tws_pkg::tws_link_s l_nxt; // link next state
  tws_pkg::tws_core_s c_r; // core state
  tws_pkg::tws_core_s c_nxt; // core next state

  logic lk_rst_n; // link domain reset, active low
  logic scl_new; // filtered clock after this edge
  logic sda_new; // filtered data after this edge
  logic scl_rise; // filtered clock rising
  logic scl_fall; // filtered clock falling
  logic start_det; // start or repeated start seen
  logic stop_det; // stop seen
  logic [6:0] eff_addr; // address chosen by pin or override
  logic [6:0] pin_addr; // address chosen by the pin alone
  logic [7:0] ovr_reg; // address override register as stored

  assign lk_rst_n = l_r.rst_sync[1];
  // a change counts once the second and third samples agree
  assign scl_new = (l_r.scl_s[1] == l_r.scl_s[2]) ? l_r.scl_s[2] : l_r.scl_q;
  assign sda_new = (l_r.sda_s[1] == l_r.sda_s[2]) ? l_r.sda_s[2] : l_r.sda_q;
  assign scl_rise = scl_new & ~l_r.scl_q;
  assign scl_fall = ~scl_new & l_r.scl_q;
  assign start_det = l_r.scl_q & scl_new & l_r.sda_q & ~sda_new;
  assign stop_det = l_r.scl_q & scl_new & ~l_r.sda_q & sda_new;

  // the pin picks one of two addresses unless the override is enabled
  assign pin_addr = c_r.sel_q ? tws_pkg::ADDR_BYTE_ALT[7:1] : tws_pkg::ADDR_BYTE_DEF[7:1];
  // register offsets are cut down to the file index width on purpose
  assign ovr_reg = c_r.regs[tws_pkg::REG_OVERRIDE[tws_pkg::REG_IDX_W-1:0]];
  assign eff_addr = ovr_reg[tws_pkg::OVR_EN_BIT] ? ovr_reg[7:1] : pin_addr;

  // outputs straight from flip-flops
  assign sda_o = l_r.sda_out;
  assign sda_oe_n = l_r.sda_oe_n;
  assign ctrl_o = c_r.regs[tws_pkg::REG_CTRL[tws_pkg::REG_IDX_W-1:0]];

  // link next state: sampling, start and stop, bit engine
  always_comb begin
    l_nxt = l_r;
    l_nxt.rst_sync = {l_r.rst_sync[0], reset_n};
    l_nxt.scl_s = {l_r.scl_s[1:0], scl_i};
    l_nxt.sda_s = {l_r.sda_s[1:0], sda_i};
    l_nxt.scl_q = scl_new;
    l_nxt.sda_q = sda_new;
    l_nxt.atg_s = {l_r.atg_s[1:0], c_r.addr_tgl};
    l_nxt.akt_s = {l_r.akt_s[1:0], c_r.ack_tgl};
    // take a new slave address when the core toggles
    if (l_r.atg_s[1] != l_r.atg_s[2]) begin
      l_nxt.my_addr = c_r.sent_addr;
    end
    // take a read answer when the core toggles
    if (l_r.akt_s[1] != l_r.akt_s[2]) begin
      l_nxt.rd_buf = c_r.rdata;
    end
    if (start_det) begin
      // start or restart always begins a new address byte
      l_nxt.st = tws_pkg::ST_ADDR;
      l_nxt.cnt = 4'h0;
      l_nxt.sda_oe_n = 1'b1;
    end else if (stop_det) begin
      // stop returns the link to idle with the line released
      l_nxt.st = tws_pkg::ST_IDLE;
      l_nxt.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (l_r.st)
        // receiving states sample one bit per clock, msb first
        tws_pkg::ST_ADDR, tws_pkg::ST_RAH, tws_pkg::ST_RAL, tws_pkg::ST_WDAT: begin
          l_nxt.shift = {l_r.shift[6:0], sda_new};
          l_nxt.cnt = 4'(l_r.cnt + 4'h1);
        end
        // master acknowledge after a read byte
        tws_pkg::ST_RMACK: begin
          if (sda_new) begin
            l_nxt.st = tws_pkg::ST_IGNORE; // no-acknowledge ends the read
          end else begin
            l_nxt.reg_addr = 16'(l_r.reg_addr + 16'h0001);
            l_nxt.req_addr = 16'(l_r.reg_addr + 16'h0001);
            l_nxt.req_wr = 1'b0;
            l_nxt.req_tgl = ~l_r.req_tgl;
          end
        end
        default: begin
          l_nxt.cnt = l_r.cnt; // nothing sampled elsewhere
        end
      endcase
    end else if (scl_fall) begin
      // all line changes happen on the falling edge
      case (l_r.st)
        // address byte: compare bits 7..1, bit 0 is direction
        tws_pkg::ST_ADDR: begin
          if (l_r.cnt == tws_pkg::BITS_PER_BYTE) begin
            if (l_r.shift[7:1] == l_r.my_addr) begin
              l_nxt.st = tws_pkg::ST_AACK;
              l_nxt.sda_oe_n = 1'b0;
              l_nxt.rd_mode = (l_r.shift[tws_pkg::DIR_BIT] == tws_pkg::DIR_READ);
              if (l_r.shift[tws_pkg::DIR_BIT] == tws_pkg::DIR_READ) begin
                l_nxt.req_addr = l_r.reg_addr;
                l_nxt.req_wr = 1'b0;
                l_nxt.req_tgl = ~l_r.req_tgl;
              end
            end else begin
              l_nxt.st = tws_pkg::ST_IGNORE; // not our address
            end
          end
        end
        // end of address acknowledge: read data out or take register address
        tws_pkg::ST_AACK: begin
          l_nxt.cnt = 4'h0;
          l_nxt.sda_oe_n = 1'b1;
          if (l_r.rd_mode) begin
            l_nxt.st = tws_pkg::ST_RDAT;
            l_nxt.sda_oe_n = l_r.rd_buf[7];
            l_nxt.shift = {l_r.rd_buf[6:0], 1'b1};
            l_nxt.cnt = 4'h1;
          end else begin
            l_nxt.st = tws_pkg::ST_RAH;
          end
        end
        // register address high byte first
        tws_pkg::ST_RAH: begin
          if (l_r.cnt == tws_pkg::BITS_PER_BYTE) begin
            l_nxt.reg_addr[15:8] = l_r.shift;
            l_nxt.st = tws_pkg::ST_HACK;
            l_nxt.sda_oe_n = 1'b0;
          end
        end
        tws_pkg::ST_HACK: begin
          l_nxt.sda_oe_n = 1'b1;
          l_nxt.cnt = 4'h0;
          l_nxt.st = tws_pkg::ST_RAL;
        end
        // register address low byte
        tws_pkg::ST_RAL: begin
          if (l_r.cnt == tws_pkg::BITS_PER_BYTE) begin
            l_nxt.reg_addr[7:0] = l_r.shift;
            l_nxt.st = tws_pkg::ST_LACK;
            l_nxt.sda_oe_n = 1'b0;
          end
        end
        tws_pkg::ST_LACK: begin
          l_nxt.sda_oe_n = 1'b1;
          l_nxt.cnt = 4'h0;
          l_nxt.st = tws_pkg::ST_WDAT;
        end
        // write data byte: post to the core, step the pointer
        tws_pkg::ST_WDAT: begin
          if (l_r.cnt == tws_pkg::BITS_PER_BYTE) begin
            l_nxt.req_addr = l_r.reg_addr;
            l_nxt.req_data = l_r.shift;
            l_nxt.req_wr = 1'b1;
            l_nxt.req_tgl = ~l_r.req_tgl;
            l_nxt.reg_addr = 16'(l_r.reg_addr + 16'h0001);
            l_nxt.st = tws_pkg::ST_DACK;
            l_nxt.sda_oe_n = 1'b0;
          end
        end
        tws_pkg::ST_DACK: begin
          l_nxt.sda_oe_n = 1'b1;
          l_nxt.cnt = 4'h0;
          l_nxt.st = tws_pkg::ST_WDAT;
        end
        // read data byte: shift out, release for master acknowledge
        tws_pkg::ST_RDAT: begin
          if (l_r.cnt == tws_pkg::BITS_PER_BYTE) begin
            l_nxt.sda_oe_n = 1'b1;
            l_nxt.st = tws_pkg::ST_RMACK;
          end else begin
            l_nxt.sda_oe_n = l_r.shift[7];
            l_nxt.shift = {l_r.shift[6:0], 1'b1};
            l_nxt.cnt = 4'(l_r.cnt + 4'h1);
          end
        end
        // master acknowledged: next byte starts
        tws_pkg::ST_RMACK: begin
          l_nxt.st = tws_pkg::ST_RDAT;
          l_nxt.sda_oe_n = l_r.rd_buf[7];
          l_nxt.shift = {l_r.rd_buf[6:0], 1'b1};
          l_nxt.cnt = 4'h1;
        end
        default: begin
          l_nxt.sda_oe_n = 1'b1; // idle and ignore keep the line free
        end
      endcase
    end
    // synchronous reset, reset synchroniser kept running
    if (!lk_rst_n) begin
      l_nxt = '0;
      l_nxt.rst_sync = {l_r.rst_sync[0], reset_n};
      l_nxt.scl_s = 3'h7;
      l_nxt.sda_s = 3'h7;
      l_nxt.scl_q = 1'b1;
      l_nxt.sda_q = 1'b1;
      l_nxt.my_addr = tws_pkg::ADDR_BYTE_DEF[7:1];
      l_nxt.st = tws_pkg::ST_IDLE;
      l_nxt.sda_oe_n = 1'b1;
    end
  end

  // link register
  always_ff @(posedge link_clk) begin
    l_r <= l_nxt;
  end

  // core next state: pin filter, address offer, register access
  always_comb begin
    c_nxt = c_r;
    c_nxt.sel_s = {c_r.sel_s[1:0], address_select_pin};
    if (c_r.sel_s[1] == c_r.sel_s[2]) begin
      c_nxt.sel_q = c_r.sel_s[2];
    end
    // offer a changed address to the link by toggle
    if (eff_addr != c_r.sent_addr) begin
      c_nxt.sent_addr = eff_addr;
      c_nxt.addr_tgl = ~c_r.addr_tgl;
    end
    c_nxt.rqt_s = {c_r.rqt_s[1:0], l_r.req_tgl};
    // a request toggle from the link: fields are held stable
    if (c_r.rqt_s[1] != c_r.rqt_s[2]) begin
      if (l_r.req_wr) begin
        // writes to the status register and unmapped space are dropped
        if (l_r.req_addr < tws_pkg::REG_LIMIT && l_r.req_addr != tws_pkg::REG_STATUS) begin
          c_nxt.regs[l_r.req_addr[tws_pkg::REG_IDX_W-1:0]] = l_r.req_data;
          c_nxt.wr_count = 8'(c_r.wr_count + 8'h01);
        end
      end else begin
        // reads answer zero outside the register file
        if (l_r.req_addr >= tws_pkg::REG_LIMIT) begin
          c_nxt.rdata = 8'h00;
        end else if (l_r.req_addr == tws_pkg::REG_STATUS) begin
          c_nxt.rdata = c_r.wr_count;
        end else begin
          c_nxt.rdata = c_r.regs[l_r.req_addr[tws_pkg::REG_IDX_W-1:0]];
        end
        c_nxt.ack_tgl = ~c_r.ack_tgl;
      end
    end
    if (!reset_n) begin
      c_nxt = '0;
      c_nxt.regs = {tws_pkg::REG_COUNT{tws_pkg::REG_RESET}};
      c_nxt.sent_addr = tws_pkg::ADDR_BYTE_DEF[7:1];
    end
  end

  // core register
  always_ff @(posedge clk) begin
    c_r <= c_nxt;
  end

  // checks on the link domain: each names link_clk and sleeps while the link reset holds
  sequence s_byte_done(tws_pkg::tws_state_e s);
    scl_fall && l_r.st == s && l_r.cnt == tws_pkg::BITS_PER_BYTE;
  endsequence

  a_idle_free: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    l_r.st == tws_pkg::ST_IDLE |-> l_r.sda_oe_n)
    else $error("data line held while link idle");
  a_stop_idle: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    stop_det |=> l_r.st == tws_pkg::ST_IDLE && l_r.sda_oe_n)
    else $error("stop did not free the link");
  a_start_seen: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    start_det |=> l_r.st == tws_pkg::ST_ADDR && l_r.cnt == 4'h0)
    else $error("start not taken");
  a_restart_new: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    start_det && l_r.st == tws_pkg::ST_WDAT ##1 1'b1 |-> l_r.sda_oe_n)
    else $error("restart left data line driven");
  a_addr_match: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    s_byte_done(tws_pkg::ST_ADDR) ##0 l_r.shift[7:1] == l_r.my_addr
    |=> l_r.st == tws_pkg::ST_AACK && !l_r.sda_oe_n)
    else $error("own address not acknowledged");
  a_addr_foreign: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    s_byte_done(tws_pkg::ST_ADDR) ##0 l_r.shift[7:1] != l_r.my_addr
    |=> l_r.st == tws_pkg::ST_IGNORE && l_r.sda_oe_n)
    else $error("foreign address answered");
  a_msb_first: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    scl_fall && l_r.st == tws_pkg::ST_RDAT && l_r.cnt < tws_pkg::BITS_PER_BYTE
    |=> l_r.sda_oe_n == $past(l_r.shift[7]))
    else $error("read bit out of order");
  a_read_release: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    s_byte_done(tws_pkg::ST_RDAT) |=> l_r.sda_oe_n && l_r.st == tws_pkg::ST_RMACK)
    else $error("data line kept for master acknowledge");
  a_ack_low: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    l_r.st inside {tws_pkg::ST_AACK, tws_pkg::ST_HACK, tws_pkg::ST_LACK, tws_pkg::ST_DACK}
    |-> !l_r.sda_oe_n)
    else $error("acknowledge not driven low");
  a_one_bit: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    scl_rise && l_r.st == tws_pkg::ST_WDAT |=> l_r.cnt == 4'($past(l_r.cnt) + 4'h1))
    else $error("bit count not stepped once");
  a_sda_stable: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    $fell(l_r.sda_oe_n) |-> !l_r.scl_q)
    else $error("data line pulled while clock high");
  a_addr_high: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    s_byte_done(tws_pkg::ST_RAH) |=> l_r.reg_addr[15:8] == $past(l_r.shift)
    ##1 l_r.st == tws_pkg::ST_HACK)
    else $error("register address high byte lost");
  a_write_post: assert property (@(posedge link_clk) disable iff (!lk_rst_n)
    s_byte_done(tws_pkg::ST_WDAT)
    |=> l_r.req_wr && l_r.req_tgl != $past(l_r.req_tgl))
    else $error("write byte not posted");

  // checks on the core domain
  a_ovr_addr: assert property (@(posedge clk) disable iff (!reset_n)
    c_r.regs[0][tws_pkg::OVR_EN_BIT] ##1 c_r.regs[0][tws_pkg::OVR_EN_BIT] && $stable(c_r.regs[0])
    |-> c_r.sent_addr == c_r.regs[0][7:1])
    else $error("override address not offered");
  a_pin_addr: assert property (@(posedge clk) disable iff (!reset_n)
    !c_r.regs[0][tws_pkg::OVR_EN_BIT] && c_r.sel_q ##1 !c_r.regs[0][tws_pkg::OVR_EN_BIT] && c_r.sel_q
    |-> c_r.sent_addr == tws_pkg::ADDR_BYTE_ALT[7:1])
    else $error("alternate address not offered");
  // a taken write to a mapped byte bumps the counter, a status write leaves all alone
  a_write_count: assert property (@(posedge clk) disable iff (!reset_n)
    c_r.rqt_s[1] != c_r.rqt_s[2] && l_r.req_wr && l_r.req_addr < tws_pkg::REG_LIMIT
    && l_r.req_addr != tws_pkg::REG_STATUS |=> c_r.wr_count == 8'($past(c_r.wr_count) + 8'h01))
    else $error("accepted write not counted");
  a_status_ro: assert property (@(posedge clk) disable iff (!reset_n)
    c_r.rqt_s[1] != c_r.rqt_s[2] && l_r.req_wr && l_r.req_addr == tws_pkg::REG_STATUS
    |=> $stable(c_r.regs) && $stable(c_r.wr_count))
    else $error("status register took a write");

endmodule

// *** dv/tws_master_model.sv ***
// two-wire bus master model driving the register slave
// assumes the bench resolves the open-drain data wire and feeds it back
`timescale 1ns/100ps
module tws_master_model (
  input wire logic clk, // bench clock, lines change at its falling edge
  input wire logic sda_line, // resolved data wire
  output logic scl_o, // serial clock, master only
  output logic sda_drv // data drive, 1 releases to the pull-up
);
  localparam int QTR = 12; // quarter bit, over 7 link cycles
  localparam int HIGH = 24; // clock high phase, 15 link cycles

  // idle bus: both lines high
  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end

  // waits a number of falling bench clock edges
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_drv = 1'b1;
    gap(QTR);
    scl_o = 1'b1;
    gap(QTR);
    sda_drv = 1'b0;
    gap(QTR);
    scl_o = 1'b0;
    gap(QTR);
  endtask

  // stop: data rises while the clock is high, then idle spacing
  task automatic stop_cond();
    sda_drv = 1'b0;
    gap(QTR);
    scl_o = 1'b1;
    gap(QTR);
    sda_drv = 1'b1;
    gap(2 * HIGH);
  endtask

  // one clock period carrying one bit; wire sampled late in the high phase
  task automatic clock_bit(input logic b, output logic seen);
    sda_drv = b;
    gap(QTR);
    scl_o = 1'b1;
    gap(HIGH);
    seen = sda_line;
    scl_o = 1'b0;
    gap(QTR);
  endtask

  // sends a byte msb first, then releases the wire for the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, ack_n);
  endtask

  // receives a byte msb first, then answers ack (0) or nack (1)
  task automatic get_byte(input logic ack_n, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, b[i]);
    end
    clock_bit(ack_n, s);
  endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the two-wire register slave
// assumes tws_master_model as the bus master and an open-drain pulled-up data wire
`timescale 1ns/100ps
module tb;
  logic clk, link_clk, reset_n, address_select_pin; // bench driven inputs
  logic sda_o, sda_oe_n, scl_m, sda_m; // design and master drives
  logic [7:0] ctrl_o; // control port
  wire logic sda_wire; // resolved data line
  int fail_count, checks, seed; // counters and random seed
  logic [7:0] shadow [16]; // expected register contents
  logic [7:0] wq [$]; // bytes of the next write
  logic [7:0] wr_total; // accepted writes, wrapping like the status register

  // open drain with pull-up: low only when someone pulls
  assign sda_wire = sda_m & (sda_oe_n | sda_o);

  tws_register_slave DUT (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(scl_m),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
    .ctrl_o(ctrl_o));
  tws_master_model mst (.clk(clk), .sda_line(sda_wire), .scl_o(scl_m), .sda_drv(sda_m));

  // core clock 50 MHz and free-running link clock 32 ns with odd phase
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // prints counts and verdict, then ends the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compares one byte result
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // compares one bit result
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // expected read value: status counts writes, mapped registers from the shadow, others read zero
  function automatic logic [7:0] exp_read(input logic [15:0] ra);
    if (ra == tws_pkg::REG_STATUS) begin
      return wr_total;
    end
    return (ra < tws_pkg::REG_LIMIT) ? shadow[ra[3:0]] : tws_pkg::REG_RESET;
  endfunction

  // write-form address byte chosen by the select pin
  function automatic logic [7:0] pin_addr(input logic pin);
    return pin ? tws_pkg::ADDR_BYTE_ALT : tws_pkg::ADDR_BYTE_DEF;
  endfunction

  // addressed write of wq; hit says whether the slave should answer
  task automatic wr_regs(input logic [7:0] ab, input logic [15:0] ra, input logic hit);
    logic a;
    logic [15:0] p;
    mst.start_cond();
    mst.put_byte(ab, a);
    cmp_bit(a, ~hit, "address ack");
    mst.put_byte(ra[15:8], a);
    cmp_bit(a, ~hit, "reg high ack");
    mst.put_byte(ra[7:0], a);
    cmp_bit(a, ~hit, "reg low ack");
    for (int i = 0; i < wq.size(); i++) begin
      mst.put_byte(wq[i], a);
      cmp_bit(a, ~hit, "data ack");
      p = ra + 16'(i);
      if (hit && p < tws_pkg::REG_LIMIT && p != tws_pkg::REG_STATUS) begin
        shadow[p[3:0]] = wq[i];
        wr_total = 8'(wr_total + 8'h01);
      end
    end
    mst.stop_cond();
    cmp_bit(sda_oe_n, 1'b1, "line released when idle");
    cmp_byte(ctrl_o, shadow[2], "control port");
  endtask

  // pointer set, repeated start, burst read of n bytes, last one nacked
  task automatic rd_regs(input logic [7:0] ab, input logic [15:0] ra, input int n);
    logic a;
    logic [7:0] d;
    mst.start_cond();
    mst.put_byte(ab, a);
    cmp_bit(a, 1'b0, "address ack");
    mst.put_byte(ra[15:8], a);
    mst.put_byte(ra[7:0], a);
    cmp_bit(a, 1'b0, "reg low ack");
    mst.start_cond(); // repeated start
    mst.put_byte(ab | 8'h01, a);
    cmp_bit(a, 1'b0, "read address ack");
    for (int i = 0; i < n; i++) begin
      mst.get_byte(logic'(i == n - 1), d);
      cmp_byte(d, exp_read(ra + 16'(i)), "read data");
    end
    mst.stop_cond();
  endtask

  // reports the end of one test
  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  // bounds the whole run
  initial begin
    repeat (100000) @(negedge clk);
    fail_count++;
    $display("FAIL %0t run did not finish", $time);
    stop_test();
  end

  // main sequence
  initial begin
    logic [15:0] ra;
    int n;
    seed = 48768;
    fail_count = 0;
    checks = 0;
    wr_total = 8'h00;
    reset_n = 1'b0;
    address_select_pin = 1'b0;
    foreach (shadow[i]) shadow[i] = tws_pkg::REG_RESET;
    repeat (10) @(negedge clk);
    cmp_bit(sda_oe_n, 1'b1, "reset release");
    cmp_bit(sda_o, 1'b0, "pull level");
    cmp_byte(ctrl_o, 8'h00, "reset control");
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    wq = {8'($random(seed))};
    wr_regs(pin_addr(1'b0), 16'h0002, 1'b1);
    rd_regs(pin_addr(1'b0), 16'h0002, 1);
    end_test("control write and read");
    wq = {8'h5a};
    wr_regs(pin_addr(1'b1), 16'h0003, 1'b0);
    end_test("foreign address");
    address_select_pin = 1'b1;
    repeat (40) @(negedge clk);
    wr_regs(pin_addr(1'b0), 16'h0003, 1'b0);
    wq = {8'($random(seed))};
    wr_regs(pin_addr(1'b1), 16'h0003, 1'b1);
    rd_regs(pin_addr(1'b1), 16'h0003, 1);
    address_select_pin = 1'b0;
    repeat (40) @(negedge clk);
    end_test("alternate address");
    wq = {8'h21};
    wr_regs(pin_addr(1'b0), 16'h0000, 1'b1);
    repeat (40) @(negedge clk);
    wq = {8'($random(seed))};
    wr_regs(8'h20, 16'h0004, 1'b1);
    wr_regs(pin_addr(1'b0), 16'h0004, 1'b0);
    rd_regs(8'h20, 16'h0004, 1);
    end_test("address override");
    for (int k = 0; k < 4; k++) begin
      ra = (k == 3) ? 16'h000f : 16'(2 + ($unsigned($random(seed)) % 14));
      n = (k == 3) ? 2 : 1 + ($unsigned($random(seed)) % 3);
      wq = {};
      repeat (n) wq.push_back(8'($random(seed)));
      wr_regs(8'h20, ra, 1'b1);
      rd_regs(8'h20, ra, n);
    end
    end_test("random bursts");
    wq = {8'($random(seed))};
    wr_regs(8'h20, tws_pkg::REG_STATUS, 1'b1);
    rd_regs(8'h20, tws_pkg::REG_OVERRIDE, 2);
    end_test("status counter");
    stop_test();
  end
endmodule
